// >>> inc/status_regs_cfg.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the status, event log and converter result register bank.
 * Assumes inclusion by bare name from design files.
 */
`ifndef STATUS_REGS_CFG_SVH
`define STATUS_REGS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (low three address bits only)
// ----------------------------------------------------------------------
`define OFS_CONTROL      3'h0
`define OFS_ALERT_EN     3'h1
`define OFS_STATUS       3'h2
`define OFS_FAULT        3'h3
`define OFS_SENSE        3'h4
`define OFS_SOURCE       3'h5
`define OFS_AUX          3'h6
`define OFS_AUX_ALIAS    3'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_FET_ON       7
`define BIT_GPIO         6
`define BIT_SHORT        5
`define BIT_PRESENT      4
`define BIT_PWR_BAD      3
`define BIT_OVERCUR      2
`define BIT_UNDERV       1
`define BIT_OVERV        0
`define CTL_TEST_MODE    5
`define CTL_FET_CMD      3

// ----------------------------------------------------------------------
// Reset values and thresholds
// ----------------------------------------------------------------------
`define CONTROL_RST      8'h1b
`define ALERT_EN_RST     8'h00
`define FAULT_RST        8'h00
`define ADC_RST          8'h00
`define SHORT_CODE       8'h07
`define FAULT_MASK       8'h3f

// ----------------------------------------------------------------------
// Timing: each channel request follows CONV_TIME_US microseconds after the previous answer
// ----------------------------------------------------------------------
`define CLK_MHZ          100
`define CONV_TIME_US     10
`define CONV_CYCLES      (`CONV_TIME_US * `CLK_MHZ)

`endif

// >>> inc/status_regs_pkg.sv
/*
 * Types for the status and converter register bank.
 * Assumes nothing of its surroundings.
 */
package status_regs_pkg;
    typedef enum logic [1:0] {
        CH_SENSE  = 2'b00,
        CH_SOURCE = 2'b01,
        CH_AUX    = 2'b11
    } adc_chan_t;
endpackage

// >>> logic/status_regs.sv
/*
 * Status, sticky event log and converter result register bank with
 * the control and alert enable registers it depends on.
 * Assumes a serial bus front end supplying one-cycle read and write
 * strobes with an address byte, and a converter delivering one result
 * per request on the channel selected here.
 * The comparator, presence, power-good and cool-down inputs are taken
 * as already synchronous to clk, so edges are found by a single stage.
 * The converter may answer after any number of cycles; an answer that
 * is still pending when test mode is entered is dropped, and the
 * rotation resumes on the same channel once test mode is left.
 */
`timescale 1ns/1ns
`default_nettype none
`include "status_regs_cfg.svh"

module status_regs
    import status_regs_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       fet_on,
    input  wire logic       gpio_in,
    input  wire logic       card_presence_input,
    input  wire logic       power_good_feedback_input,
    input  wire logic       overcurrent_cooldown,
    input  wire logic       overcurrent_fault,
    input  wire logic       undervoltage_comparator_input,
    input  wire logic       overvoltage_comparator_input,
    output logic            conv_start,
    output var adc_chan_t   conv_chan,
    input  wire logic       conv_done,
    input  wire logic [7:0] conv_data,
    output logic            alert_n,
    output logic      [7:0] control,
    output logic      [7:0] alert_enable
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  alert_en;
        logic [7:0]  fault;
        logic [7:0]  sense;
        logic [7:0]  source;
        logic [7:0]  aux;
        logic [7:0]  rdata;
        logic        card_prev;
        logic        pg_prev;
        logic        uv_prev;
        logic        ov_prev;
        logic        alert_n;
        logic        busy;
        adc_chan_t   chan;
        logic [31:0] timer;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [2:0] addr;
    logic [7:0] status;
    logic [7:0] events;
    logic       test_mode;
    logic       wr_fault;

    // ------------------------------------------------------------------
    // Decoded strobes and next values
    // ------------------------------------------------------------------
    localparam logic [7:0] LOG_MASK = `FAULT_MASK;
    logic       wr_control;
    logic       wr_alert_en;
    logic       wr_sense;
    logic       wr_source;
    logic       wr_aux;
    logic [7:0] rd_mux;
    logic       conv_take;
    logic       conv_due;
    adc_chan_t  chan_next;
    logic [7:0] fault_next;

    // ------------------------------------------------------------------
    // Address and mode
    // ------------------------------------------------------------------
    always_comb begin
        addr      = reg_addr[2:0];
        test_mode = s_q.control[`CTL_TEST_MODE];
        wr_fault  = reg_wr && (addr == `OFS_FAULT);
    end

    // ------------------------------------------------------------------
    // Live status
    // ------------------------------------------------------------------
    always_comb begin
        status    = 8'h00;
        status[`BIT_FET_ON]  = fet_on;
        status[`BIT_GPIO]    = gpio_in;
        status[`BIT_SHORT]   = !s_q.control[`CTL_FET_CMD]
                               && (s_q.sense > `SHORT_CODE);
        status[`BIT_PRESENT] = !card_presence_input;
        status[`BIT_PWR_BAD] = !power_good_feedback_input;
        status[`BIT_OVERCUR] = overcurrent_cooldown;
        status[`BIT_UNDERV]  = !undervoltage_comparator_input;
        status[`BIT_OVERV]   = overvoltage_comparator_input;
    end

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    always_comb begin
        events = 8'h00;
        events[`BIT_SHORT]   = status[`BIT_SHORT];
        events[`BIT_PRESENT] = card_presence_input != s_q.card_prev;
        events[`BIT_PWR_BAD] = s_q.pg_prev && !power_good_feedback_input;
        events[`BIT_OVERCUR] = overcurrent_fault;
        events[`BIT_UNDERV]  = s_q.uv_prev && !undervoltage_comparator_input;
        events[`BIT_OVERV]   = !s_q.ov_prev && overvoltage_comparator_input;
    end

    // ------------------------------------------------------------------
    // Write decode; the status offset has no strobe, offset 7 aliases aux
    // ------------------------------------------------------------------
    always_comb begin
        wr_control  = reg_wr && (addr == `OFS_CONTROL);
        wr_alert_en = reg_wr && (addr == `OFS_ALERT_EN);
        wr_sense    = reg_wr && test_mode && (addr == `OFS_SENSE);
        wr_source   = reg_wr && test_mode && (addr == `OFS_SOURCE);
        wr_aux      = reg_wr && test_mode
                      && ((addr == `OFS_AUX) || (addr == `OFS_AUX_ALIAS));
    end

    // ------------------------------------------------------------------
    // Sticky event log, one cell per bit; a new event wins over a clear
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_log
        always_comb begin
            if (!LOG_MASK[i]) begin
                fault_next[i] = 1'b0;
            end else if (events[i]) begin
                fault_next[i] = 1'b1;
            end else if (wr_fault && !reg_wdata[i]) begin
                fault_next[i] = 1'b0;
            end else begin
                fault_next[i] = s_q.fault[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion control: fixed channel rotation
    // ------------------------------------------------------------------
    always_comb begin
        conv_take = s_q.busy && conv_done && !test_mode;
        conv_due  = !s_q.busy && !test_mode
                    && (s_q.timer >= 32'(CONV_CYCLES - 1));
        case (s_q.chan)
            CH_SENSE:  chan_next = CH_SOURCE;
            CH_SOURCE: chan_next = CH_AUX;
            default:   chan_next = CH_SENSE;
        endcase
    end

    // ------------------------------------------------------------------
    // Read multiplexer; address 7 falls through to the auxiliary result
    // ------------------------------------------------------------------
    always_comb begin
        case (addr)
            `OFS_CONTROL:  rd_mux = s_q.control;
            `OFS_ALERT_EN: rd_mux = s_q.alert_en;
            `OFS_STATUS:   rd_mux = status;
            `OFS_FAULT:    rd_mux = s_q.fault;
            `OFS_SENSE:    rd_mux = s_q.sense;
            `OFS_SOURCE:   rd_mux = s_q.source;
            default:       rd_mux = s_q.aux;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.card_prev = card_presence_input;
        s_d.pg_prev   = power_good_feedback_input;
        s_d.uv_prev   = undervoltage_comparator_input;
        s_d.ov_prev   = overvoltage_comparator_input;

        // Register writes; the status offset has no strobe, offset 7 aliases aux
        if (wr_control) begin
            s_d.control = reg_wdata;
        end
        if (wr_alert_en) begin
            s_d.alert_en = reg_wdata;
        end
        if (wr_sense) begin
            s_d.sense = reg_wdata;
        end
        if (wr_source) begin
            s_d.source = reg_wdata;
        end
        if (wr_aux) begin
            s_d.aux = reg_wdata;
        end

        // Sticky log
        s_d.fault = fault_next;

        // Alert low while any enabled log bit is set
        s_d.alert_n = !(|(s_d.fault & s_d.alert_en));

        // Conversion sequencing, halted in test mode
        if (test_mode) begin
            s_d.busy  = 1'b0;
            s_d.timer = '0;
        end else if (conv_take) begin
            s_d.busy = 1'b0;
            s_d.chan = chan_next;
            case (s_q.chan)
                CH_SENSE:  s_d.sense  = conv_data;
                CH_SOURCE: s_d.source = conv_data;
                CH_AUX:    s_d.aux    = conv_data;
                default:   s_d.aux    = s_q.aux;
            endcase
        end else if (conv_due) begin
            s_d.timer = '0;
            s_d.busy  = 1'b1;
        end else if (!s_q.busy) begin
            s_d.timer = s_q.timer + 32'd1;
        end

        // Read data register
        if (reg_rd) begin
            s_d.rdata = rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.rdata     <= 8'h00;
            s_q.busy      <= 1'b0;
            s_q.timer     <= '0;
            s_q.control   <= `CONTROL_RST;
            s_q.alert_en  <= `ALERT_EN_RST;
            s_q.fault     <= `FAULT_RST;
            s_q.sense     <= `ADC_RST;
            s_q.source    <= `ADC_RST;
            s_q.aux       <= `ADC_RST;
            s_q.card_prev <= 1'b1;
            s_q.pg_prev   <= 1'b1;
            s_q.uv_prev   <= 1'b1;
            s_q.ov_prev   <= 1'b0;
            s_q.alert_n   <= 1'b1;
            s_q.chan      <= CH_SENSE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata    = s_q.rdata;
    assign alert_n      = s_q.alert_n;
    assign control      = s_q.control;
    assign alert_enable = s_q.alert_en;
    assign conv_start   = s_q.busy && !test_mode;
    assign conv_chan    = s_q.chan;

endmodule
`default_nettype wire

// >>> bench/status_regs_monitor.sv
/* Checker for the status bank ports.
   Bound to status_regs from the testbench top file. */
`timescale 1ns/1ns
`default_nettype none
module status_regs_monitor
    import status_regs_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       fet_on,
    input wire logic       gpio_in,
    input wire logic       card_presence_input,
    input wire logic       power_good_feedback_input,
    input wire logic       overcurrent_cooldown,
    input wire logic       undervoltage_comparator_input,
    input wire logic       overvoltage_comparator_input,
    input wire logic       alert_n,
    input wire logic [7:0] alert_enable,
    input wire logic [7:0] control,
    input wire logic       conv_start,
    input wire adc_chan_t  conv_chan,
    input wire logic       conv_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd;
        reg_rd && reg_addr[2:0] == 3'h2;
    endsequence
    property p_fet; s_rd ##0 $stable(fet_on) |=> reg_rdata[7] == $past(fet_on); endproperty
    a_fet: assert property (p_fet) else $error("fet bit wrong");
    property p_gpio; s_rd ##0 $stable(gpio_in) |=> reg_rdata[6] == $past(gpio_in); endproperty
    a_gpio: assert property (p_gpio) else $error("pin bit wrong");
    property p_card; s_rd ##0 $stable(card_presence_input) |=> reg_rdata[4] != $past(card_presence_input); endproperty
    a_card: assert property (p_card) else $error("card bit wrong");
    property p_pg; s_rd ##0 $stable(power_good_feedback_input) |=> reg_rdata[3] != $past(power_good_feedback_input);
    endproperty
    a_pg: assert property (p_pg) else $error("power bit wrong");
    property p_oc; s_rd ##0 $stable(overcurrent_cooldown) |=> reg_rdata[2] == $past(overcurrent_cooldown); endproperty
    a_oc: assert property (p_oc) else $error("cool-down bit wrong");
    property p_uv; s_rd ##0 $stable(undervoltage_comparator_input)
        |=> reg_rdata[1] != $past(undervoltage_comparator_input); endproperty
    a_uv: assert property (p_uv) else $error("under bit wrong");
    property p_ov; s_rd ##0 $stable(overvoltage_comparator_input)
        |=> reg_rdata[0] == $past(overvoltage_comparator_input); endproperty
    a_ov: assert property (p_ov) else $error("over bit wrong");
    property p_alert; $rose(overvoltage_comparator_input) && alert_enable[0] |-> ##[1:2] !alert_n; endproperty
    a_alert: assert property (p_alert) else $error("alert missing");
    sequence s_take;
        conv_start && conv_done;
    endsequence
    property p_order;
        s_take |=> !conv_start && conv_chan == ($past(conv_chan) == CH_SENSE ? CH_SOURCE
            : $past(conv_chan) == CH_SOURCE ? CH_AUX : CH_SENSE);
    endproperty
    a_order: assert property (p_order) else $error("channel rotation wrong");
    property p_halt; control[5] |-> !conv_start ##1 $stable(conv_chan); endproperty
    a_halt: assert property (p_halt) else $error("converter ran in test mode");
endmodule
`default_nettype wire

// >>> bench/adc_model.sv
/* Converter stand-in: answers each request with the selected channel
   value, alternately at once and three cycles late. */
`timescale 1ns/1ns
`default_nettype none
module adc_model
    import status_regs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire adc_chan_t  chan,
    input  wire logic [7:0] v0,
    input  wire logic [7:0] v1,
    input  wire logic [7:0] v2,
    output logic            done,
    output logic      [7:0] data
);
    logic [1:0] cnt;
    logic       slow;
    logic [7:0] val;
    assign val = (chan == CH_SENSE) ? v0 : (chan == CH_SOURCE) ? v1 : v2;
    // Data lines show the inverse outside the answer cycle
    assign data = done ? val : ~val;
    always_ff @(posedge clk) begin
        if (rst || !start || done) begin
            cnt  <= 2'h0;
            done <= 1'b0;
            slow <= rst ? 1'b0 : slow;
        end else if (cnt == (slow ? 2'h3 : 2'h0)) begin
            done <= 1'b1;
            slow <= !slow;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/* Self-checking bench for the status bank.
   Uses the converter model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import status_regs_pkg::*;
    logic       clk = 0, rst = 1, rd = 0, wr = 0, f = 0, g = 0, c = 1, p = 1, oc = 0, of = 0, u = 1, v = 0;
    logic [7:0] a = 8'h00, wd = 8'h00, s0 = 8'h00, s1 = 8'h5a, s2 = 8'ha5, rdat, x, cdat;
    logic       cs, cd, al;
    logic [7:0] ctl, aen;
    adc_chan_t  ch;
    int         fails = 0, tests_run = 0, cyc = 0;
    always #5 clk = ~clk;
    status_regs #(.CONV_CYCLES(4)) uut (.clk(clk), .rst(rst), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdat), .fet_on(f), .gpio_in(g), .card_presence_input(c),
        .power_good_feedback_input(p), .overcurrent_cooldown(oc), .overcurrent_fault(of),
        .undervoltage_comparator_input(u), .overvoltage_comparator_input(v), .conv_start(cs),
        .conv_chan(ch), .conv_done(cd), .conv_data(cdat), .alert_n(al), .control(ctl), .alert_enable(aen));
    adc_model adc (.clk(clk), .rst(rst), .start(cs), .chan(ch), .v0(s0), .v1(s1), .v2(s2), .done(cd), .data(cdat));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wreg(input logic [7:0] ad, input logic [7:0] d);
        tick(1);
        a = ad; wd = d; wr = 1;
        tick(1);
        wr = 0;
    endtask
    task rreg(input logic [7:0] ad);
        tick(1);
        a = ad; rd = 1;
        tick(1);
        rd = 0; x = rdat;
    endtask
    task pins(input logic [6:0] s);
        tick(1);
        {f, g, c, p, oc, u, v} = s;
    endtask
    task t_log;
        chk({7'h00, al}, 8'h01);
        wreg(8'h01, 8'h01);
        chk(aen, 8'h01);
        wreg(8'hfb, 8'h00);
        pins(7'b0011011);
        tick(3);
        chk({7'h00, al}, 8'h00);
        pins(7'b0000001);
        of = 1;
        tick(1);
        of = 0;
        rreg(8'h03);
        chk(x, 8'h1f);
        wreg(8'h03, 8'h1e);
        chk({7'h00, al}, 8'h01);
        rreg(8'h03);
        chk(x, 8'h1e);
    endtask
    task t_status;
        pins(7'b1000101);
        rreg(8'hfa);
        chk(x, 8'h9f);
        wreg(8'h02, 8'h00);
        chk(ctl, 8'h1b);
        rreg(8'h02);
        chk(x, 8'h9f);
        pins(7'b0111010);
        rreg(8'h02);
        chk(x, 8'h40);
    endtask
    task t_adc;
        s0 = 8'h08;
        wreg(8'h00, 8'h13);
        rreg(8'h08);
        chk(x, 8'h13);
        wreg(8'h05, 8'h11);
        tick(60);
        rreg(8'h04);
        chk(x, 8'h08);
        rreg(8'h05);
        chk(x, 8'h5a);
        rreg(8'h07);
        chk(x, 8'ha5);
        rreg(8'h02);
        chk(x, 8'h60);
        rreg(8'h03);
        chk(x, 8'h3e);
        wreg(8'h00, 8'h33);
        wreg(8'h04, 8'hc3);
        tick(60);
        rreg(8'h04);
        chk(x, 8'hc3);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 0;
        t_log();
        t_status();
        t_adc();
        wrap_up();
    end
endmodule
bind status_regs status_regs_monitor mon (.*);
`default_nettype wire
